// ==== logic/srb_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the reset slice
// Assumes: APB byte address = register index * 4
// Notes: Definitions only
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH

`define SRB_IDX_CHIP_CONTROL 10'h09f
`define SRB_IDX_RESET_FLAGS 10'h0a2
`define SRB_IDX_BOOT_CONFIG 10'h0c0
`define SRB_IDX_TA_UNLOCK 10'h0c7
`define SRB_IDX_IRQ_ENABLE 10'h0a8
`define SRB_IDX_IRQ_PRIO_LO 10'h0b8
`define SRB_IDX_IRQ_PRIO_HI 10'h0b7
`define SRB_IDX_IRQ_STATUS 10'h0c8
`define SRB_IDX_PORT_LATCH 10'h080
`define SRB_IDX_PORT_MODE 10'h081

`define SRB_CC_TRIGGER 7
`define SRB_CC_PROG_FAIL 6
`define SRB_CC_BOOT_SEL 1
`define SRB_CC_PROG_EN 0
`define SRB_RF_SOFT 7
`define SRB_RF_PIN 6
`define SRB_CFG_BOOT_DEFAULT 7
`define SRB_IE_GLOBAL 31

`define SRB_CFG_RESET 8'hff
`define SRB_SP_RESET 8'h07
`define SRB_PORT_RESET 8'hff
`define SRB_TA_KEY1 8'haa
`define SRB_TA_KEY2 8'h55
`define SRB_VEC_BASE 16'h0003

`define SRB_CLK_NS 20
`define SRB_RST_HOLD_NS 160
`define SRB_RST_HOLD_CYC ((`SRB_RST_HOLD_NS + `SRB_CLK_NS - 1) / `SRB_CLK_NS)

`endif

// ==== logic/srb_pkg.sv ====
// Purpose: Types of the reset and boot select slice
// Assumes: Nothing
// Notes: Constants live in srb_defs.svh
package srb_pkg;
    typedef enum logic [1:0] {
        SRB_S_RUN = 2'b00,
        SRB_S_HOLD = 2'b01
    } srb_state_t;
    typedef enum logic [1:0] {
        SRB_RK_POR = 2'b00,
        SRB_RK_PIN = 2'b01,
        SRB_RK_SOFT = 2'b10
    } srb_kind_t;
endpackage

// ==== logic/srb_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for a pin
// Assumes: Input is asynchronous to pclk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module srb_pin_sync (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic pin_in, // Raw pin level
    output logic level_out // Filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level_reg <= 1'b1;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule

// ==== logic/srb_irq_arb.sv ====
// Purpose: Picks the interrupt to take from levels, enables and the nesting state
// Assumes: Request flags are levels held by their sources until cleared
// Notes: Ties at one level go to the lowest vector number
`timescale 1ns/1ps
module srb_irq_arb import srb_pkg::*; (
    input wire logic [17:0] req, // Request flags
    input wire logic [17:0] enable, // Per-source enables
    input wire logic [17:0] prio_hi, // Priority high bits
    input wire logic [17:0] prio_lo, // Priority low bits
    input wire logic global_en, // Global enable
    input wire logic [3:0] active, // Levels in service
    output logic go, // A request may be taken
    output logic [4:0] src, // Chosen vector number
    output logic [1:0] level // Level of the chosen source
);
    logic [2:0] thr;

    always_comb begin
        go = 1'b0;
        src = 5'h00;
        level = 2'b00;
        thr = active[3] ? 3'h4 : active[2] ? 3'h3 : active[1] ? 3'h2 : active[0] ? 3'h1 : 3'h0;
        for (int i = 0; i < 18; i++) begin
            // Strictly above every level in service, and above the current pick
            if (global_en && req[i] && enable[i] &&
                ({1'b0, prio_hi[i], prio_lo[i]} >= thr) &&
                (!go || {prio_hi[i], prio_lo[i]} > level)) begin
                go = 1'b1;
                src = 5'(i);
                level = {prio_hi[i], prio_lo[i]};
            end
        end
    end
endmodule

// ==== logic/srb_top.sv ====
// Purpose: Software reset, reset flags, boot select, reset state and interrupt vectoring
// Assumes: APB with one-cycle answer; irq_req and cpu_return_from_interrupt are on pclk
// Notes: Registers sit at byte address index * 4
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "srb_defs.svh"

module srb_top import srb_pkg::*; (
    input wire logic pclk, // System clock, 50 MHz
    input wire logic presetn, // Power-on reset, async, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic ext_reset_pin_n, // External reset pin, active low
    input wire logic [17:0] irq_req, // Interrupt flags by vector number
    input wire logic cpu_return_from_interrupt, // Core executed return from interrupt
    output logic core_reset, // Core held in reset, PC forced to zero
    output logic fetch_stall, // Core may fetch no further instruction
    output logic boot_from_loader, // Start from loader flash
    output logic ram_retained, // RAM contents valid across the last reset
    output logic [7:0] sp_preset, // Stack pointer load value
    output logic [7:0] port_latch, // Port output latches
    output logic [7:0] port_oe_n, // Port output enables, low drives
    output logic irq_take, // Pulse: core vectors now
    output logic [15:0] irq_vector, // Vector address with irq_take
    output logic [1:0] irq_level // Level of the taken interrupt
);
    function automatic logic [11:0] reg_addr(input logic [9:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    function automatic logic [15:0] vec_addr(input logic [4:0] n);
        vec_addr = `SRB_VEC_BASE + {8'h00, n, 3'b000};
    endfunction

    localparam logic [3:0] HOLD_LAST = 4'(`SRB_RST_HOLD_CYC - 1);

    srb_state_t state_reg, state_next;
    srb_kind_t kind_reg, kind_next;
    logic [3:0] cnt_reg, cnt_next, act_reg, act_next;
    logic [7:0] cc_reg, cc_next, rf_reg, rf_next, cfg_reg, cfg_next, pl_reg, pl_next;
    logic [7:0] pm_reg, pm_next, sp_reg, sp_next, oe_reg, oe_next;
    logic [1:0] ta_reg, ta_next, lvl_reg, lvl_next;
    logic [31:0] ie_reg, ie_next, prdata_reg, prdata_next;
    logic [17:0] plo_reg, plo_next, phi_reg, phi_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next, core_rst_reg, core_rst_next;
    logic stall_reg, stall_next, ram_ok_reg, ram_ok_next, take_reg, take_next;
    logic [15:0] vec_reg, vec_next;
    logic pin_level, arb_go, wr_en, setup, trig_fire, hold_done;
    logic [4:0] arb_src;
    logic [1:0] arb_lvl;

    srb_pin_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ext_reset_pin_n),
        .level_out(pin_level)
    );

    srb_irq_arb u_irq_arb (
        .req(irq_req),
        .enable(ie_reg[17:0]),
        .prio_hi(phi_reg),
        .prio_lo(plo_reg),
        .global_en(ie_reg[`SRB_IE_GLOBAL]),
        .active(act_reg),
        .go(arb_go),
        .src(arb_src),
        .level(arb_lvl)
    );

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_reg && pwrite && (state_reg == SRB_S_RUN);
    assign trig_fire = wr_en && (paddr == reg_addr(`SRB_IDX_CHIP_CONTROL)) &&
                       (ta_reg == 2'd2) && pwdata[`SRB_CC_TRIGGER];
    assign hold_done = (state_reg == SRB_S_HOLD) && (cnt_reg == HOLD_LAST);

    // APB answer: data and ready are set up during the setup phase
    always_comb begin
        pready_next = setup;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = 32'h0000_0000;
            case (paddr)
                reg_addr(`SRB_IDX_CHIP_CONTROL): begin
                    prdata_next = {24'h000000, 1'b0, cc_reg[6:0]};
                end
                reg_addr(`SRB_IDX_RESET_FLAGS): prdata_next = {24'h000000, rf_reg};
                reg_addr(`SRB_IDX_BOOT_CONFIG): prdata_next = {24'h000000, cfg_reg};
                reg_addr(`SRB_IDX_IRQ_ENABLE): prdata_next = ie_reg;
                reg_addr(`SRB_IDX_IRQ_PRIO_LO): prdata_next = {14'h0000, plo_reg};
                reg_addr(`SRB_IDX_IRQ_PRIO_HI): prdata_next = {14'h0000, phi_reg};
                reg_addr(`SRB_IDX_IRQ_STATUS): prdata_next = {14'h0000, irq_req[17:0]} |
                                                             {act_reg, 28'h0000000};
                reg_addr(`SRB_IDX_PORT_LATCH): prdata_next = {24'h000000, pl_reg};
                reg_addr(`SRB_IDX_PORT_MODE): prdata_next = {24'h000000, pm_reg};
                reg_addr(`SRB_IDX_TA_UNLOCK): prdata_next = 32'h0000_0000;
                default: begin
                    prdata_next = 32'h0000_0000;
                    pslverr_next = 1'b1;
                end
            endcase
        end
    end

    // Reset sequencer and register file
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        cnt_next = cnt_reg;
        cc_next = cc_reg;
        rf_next = rf_reg;
        cfg_next = cfg_reg;
        ta_next = ta_reg;
        ie_next = ie_reg;
        plo_next = plo_reg;
        phi_next = phi_reg;
        pl_next = pl_reg;
        pm_next = pm_reg;
        ram_ok_next = ram_ok_reg;
        stall_next = stall_reg;
        if (wr_en) begin
            ta_next = 2'd0;
            case (paddr)
                reg_addr(`SRB_IDX_TA_UNLOCK): begin
                    if (pwdata[7:0] == `SRB_TA_KEY1) begin
                        ta_next = 2'd1;
                    end else if (pwdata[7:0] == `SRB_TA_KEY2 && ta_reg == 2'd1) begin
                        ta_next = 2'd2;
                    end
                end
                reg_addr(`SRB_IDX_CHIP_CONTROL): begin
                    if (ta_reg == 2'd2) begin
                        cc_next = {pwdata[7:6], 4'h0, pwdata[1:0]};
                    end
                end
                reg_addr(`SRB_IDX_RESET_FLAGS): rf_next = {pwdata[7:6], 6'h00};
                reg_addr(`SRB_IDX_BOOT_CONFIG): cfg_next = pwdata[7:0];
                reg_addr(`SRB_IDX_IRQ_ENABLE): ie_next = {pwdata[31], 13'h0000, pwdata[17:0]};
                reg_addr(`SRB_IDX_IRQ_PRIO_LO): plo_next = pwdata[17:0];
                reg_addr(`SRB_IDX_IRQ_PRIO_HI): phi_next = pwdata[17:0];
                reg_addr(`SRB_IDX_PORT_LATCH): pl_next = pwdata[7:0];
                reg_addr(`SRB_IDX_PORT_MODE): pm_next = pwdata[7:0];
                default: ta_next = 2'd0;
            endcase
        end
        if (trig_fire) begin
            stall_next = 1'b1;
        end
        case (state_reg)
            SRB_S_RUN: begin
                if (!pin_level) begin
                    state_next = SRB_S_HOLD;
                    kind_next = SRB_RK_PIN;
                    cnt_next = 4'h0;
                end else if (trig_fire) begin
                    state_next = SRB_S_HOLD;
                    kind_next = SRB_RK_SOFT;
                    cnt_next = 4'h0;
                end
            end
            SRB_S_HOLD: begin
                stall_next = 1'b1;
                if (!pin_level) begin
                    kind_next = SRB_RK_PIN;
                    cnt_next = 4'h0;
                end else if (cnt_reg != HOLD_LAST) begin
                    cnt_next = cnt_reg + 4'h1;
                end else begin
                    state_next = SRB_S_RUN;
                    stall_next = 1'b0;
                    ram_ok_next = (kind_reg != SRB_RK_POR);
                    cc_next[`SRB_CC_TRIGGER] = 1'b0;
                    cc_next[`SRB_CC_PROG_FAIL] = 1'b0;
                    cc_next[`SRB_CC_PROG_EN] = 1'b0;
                    if (kind_reg == SRB_RK_SOFT) begin
                        rf_next[`SRB_RF_SOFT] = 1'b1;
                    end else begin
                        cc_next[`SRB_CC_BOOT_SEL] = !cfg_reg[`SRB_CFG_BOOT_DEFAULT];
                    end
                    if (kind_reg == SRB_RK_PIN) begin
                        rf_next[`SRB_RF_PIN] = 1'b1;
                    end
                end
            end
            default: state_next = SRB_S_HOLD;
        endcase
        // Chip state takes its reset values from the first held cycle on
        if (state_next == SRB_S_HOLD) begin
            ta_next = 2'd0;
            ie_next = 32'h0000_0000;
            plo_next = 18'h00000;
            phi_next = 18'h00000;
            pl_next = `SRB_PORT_RESET;
            pm_next = 8'h00;
        end
    end

    // Core-facing outputs and interrupt nesting
    always_comb begin
        core_rst_next = (state_next == SRB_S_HOLD);
        sp_next = core_rst_next ? `SRB_SP_RESET : sp_reg;
        oe_next = core_rst_next ? 8'hff : ~pm_next;
        take_next = 1'b0;
        vec_next = vec_reg;
        lvl_next = lvl_reg;
        act_next = act_reg;
        if (core_rst_next) begin
            act_next = 4'h0;
        end else begin
            if (cpu_return_from_interrupt) begin
                // Highest level in service ends first
                if (act_reg[3]) begin
                    act_next[3] = 1'b0;
                end else if (act_reg[2]) begin
                    act_next[2] = 1'b0;
                end else if (act_reg[1]) begin
                    act_next[1] = 1'b0;
                end else begin
                    act_next[0] = 1'b0;
                end
            end else if (arb_go && !take_reg && !stall_reg) begin
                take_next = 1'b1;
                vec_next = vec_addr(arb_src);
                lvl_next = arb_lvl;
                act_next[arb_lvl] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SRB_S_HOLD;
            kind_reg <= SRB_RK_POR;
            cnt_reg <= 4'h0;
            cc_reg <= 8'h00;
            rf_reg <= 8'h00;
            cfg_reg <= `SRB_CFG_RESET;
            ta_reg <= 2'd0;
            ie_reg <= 32'h0000_0000;
            plo_reg <= 18'h00000;
            phi_reg <= 18'h00000;
            pl_reg <= `SRB_PORT_RESET;
            pm_reg <= 8'h00;
            act_reg <= 4'h0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            core_rst_reg <= 1'b1;
            stall_reg <= 1'b1;
            ram_ok_reg <= 1'b0;
            sp_reg <= `SRB_SP_RESET;
            oe_reg <= 8'hff;
            take_reg <= 1'b0;
            vec_reg <= 16'h0000;
            lvl_reg <= 2'b00;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            cnt_reg <= cnt_next;
            cc_reg <= cc_next;
            rf_reg <= rf_next;
            cfg_reg <= cfg_next;
            ta_reg <= ta_next;
            ie_reg <= ie_next;
            plo_reg <= plo_next;
            phi_reg <= phi_next;
            pl_reg <= pl_next;
            pm_reg <= pm_next;
            act_reg <= act_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            core_rst_reg <= core_rst_next;
            stall_reg <= stall_next;
            ram_ok_reg <= ram_ok_next;
            sp_reg <= sp_next;
            oe_reg <= oe_next;
            take_reg <= take_next;
            vec_reg <= vec_next;
            lvl_reg <= lvl_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign core_reset = core_rst_reg;
    assign fetch_stall = stall_reg;
    assign boot_from_loader = cc_reg[`SRB_CC_BOOT_SEL];
    assign ram_retained = ram_ok_reg;
    assign sp_preset = sp_reg;
    assign port_latch = pl_reg;
    assign port_oe_n = oe_reg;
    assign irq_take = take_reg;
    assign irq_vector = vec_reg;
    assign irq_level = lvl_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence trig_write_s;
        trig_fire;
    endsequence
    sequence held_reset_s;
        core_reset [*8];
    endsequence

    trig_stall_a: assert property (trig_write_s |=> fetch_stall)
        else $error("fetch not stalled after trigger");
    hold_len_a: assert property (trig_write_s |=> held_reset_s ##1 !core_reset)
        else $error("soft reset hold length wrong");
    trig_clear_a: assert property (hold_done && pin_level |=> !cc_reg[`SRB_CC_TRIGGER])
        else $error("trigger bit not cleared");
    soft_flag_a: assert property (hold_done && pin_level && kind_reg == SRB_RK_SOFT
        |=> rf_reg[7])
        else $error("soft flag not set");
    boot_keep_a: assert property (hold_done && kind_reg == SRB_RK_SOFT && pin_level
        |=> $stable(boot_from_loader))
        else $error("boot select changed by soft reset");
    boot_load_a: assert property (hold_done && kind_reg != SRB_RK_SOFT && pin_level
        |=> boot_from_loader == !$past(cfg_reg[7]))
        else $error("boot select not loaded from config");
    no_ta_a: assert property (wr_en && paddr == reg_addr(`SRB_IDX_CHIP_CONTROL) &&
        ta_reg != 2'd2 && state_reg == SRB_S_RUN && pin_level |=> !core_reset)
        else $error("locked trigger write acted");
    pc_hold_a: assert property (!pin_level |=> core_reset)
        else $error("core not held in reset");
    sp_init_a: assert property (core_reset |-> sp_preset == 8'h07)
        else $error("stack preset wrong");
    port_rst_a: assert property (core_reset |-> port_latch == 8'hff && port_oe_n == 8'hff)
        else $error("ports not in reset state");
    ge_block_a: assert property (!ie_reg[31] |=> !irq_take)
        else $error("interrupt taken with global enable off");
    vec_map_a: assert property (irq_take |->
        irq_vector == 16'h0003 + {8'h00, $past(arb_src), 3'b000})
        else $error("vector address wrong");
    preempt_a: assert property (irq_take && $past(act_reg) != 4'h0 |->
        ({1'b0, irq_level} > ($past(act_reg[3]) ? 3'h3 : $past(act_reg[2]) ? 3'h2 :
        $past(act_reg[1]) ? 3'h1 : 3'h0)))
        else $error("preempted by non-higher level");
endmodule

// ==== tb/srb_core_model.sv ====
// Purpose: Core stand-in that notes the boot block at each start and returns from service
// Assumes: All signals on pclk
// Notes: Behavioural; a return is made only when the bench asks for one
`timescale 1ns/1ps
module srb_core_model (
    input wire logic pclk, // System clock
    input wire logic presetn, // Power-on reset, active low
    input wire logic core_reset, // Core held in reset
    input wire logic boot_from_loader, // Boot block select
    input wire logic return_from_interrupt_cmd, // Bench asks for a return
    output logic cpu_return_from_interrupt, // Return pulse to the block
    output logic boot_seen // Block of the first fetch after reset
);
    logic held_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reg <= 1'b1;
            cpu_return_from_interrupt <= 1'b0;
            boot_seen <= 1'b0;
        end else begin
            held_reg <= core_reset;
            if (held_reg && !core_reset) begin
                boot_seen <= boot_from_loader;
            end
            cpu_return_from_interrupt <= return_from_interrupt_cmd;
        end
    end
endmodule

// ==== tb/srb_testbench.sv ====
// Purpose: Self-checking bench of the reset, boot select and vectoring slice
// Assumes: APB answers within 20 cycles
// Notes: All waits are bounded
`timescale 1ns/1ps
`include "srb_defs.svh"
module testbench;
    localparam logic [11:0] a_cc = {`SRB_IDX_CHIP_CONTROL, 2'b00},
        a_rf = {`SRB_IDX_RESET_FLAGS, 2'b00}, a_cfg = {`SRB_IDX_BOOT_CONFIG, 2'b00},
        a_ta = {`SRB_IDX_TA_UNLOCK, 2'b00}, a_ie = {`SRB_IDX_IRQ_ENABLE, 2'b00},
        a_pl = {`SRB_IDX_IRQ_PRIO_LO, 2'b00}, a_ph = {`SRB_IDX_IRQ_PRIO_HI, 2'b00},
        a_lat = {`SRB_IDX_PORT_LATCH, 2'b00}, a_mode = {`SRB_IDX_PORT_MODE, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ext_reset_pin_n;
    logic return_from_interrupt_cmd, cpu_return_from_interrupt, boot_seen, core_reset, fetch_stall, boot_from_loader;
    logic ram_retained, irq_take;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [17:0] irq_req;
    logic [7:0] sp_preset, port_latch, port_oe_n;
    logic [15:0] irq_vector;
    logic [1:0] irq_level;
    int fail_count, n_tests, k, n;
    srb_top dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_reset_pin_n, .irq_req, .cpu_return_from_interrupt, .core_reset, .fetch_stall,
        .boot_from_loader, .ram_retained, .sp_preset, .port_latch, .port_oe_n, .irq_take,
        .irq_vector, .irq_level
    );
    srb_core_model core (
        .pclk, .presetn, .core_reset, .boot_from_loader, .return_from_interrupt_cmd, .cpu_return_from_interrupt, .boot_seen
    );
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task fail_out;
        fail_count++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) fail_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_run;
        for (k = 0; k < 100; k++) begin
            @(posedge pclk);
            if (core_reset === 1'b0) break;
        end
        if (k == 100) fail_out();
        #1;
    endtask
    task unlock;
        apb(1'b1, a_ta, 32'h0000_00aa);
        apb(1'b1, a_ta, 32'h0000_0055);
    endtask
    task take_wait(input logic [15:0] v, input logic [1:0] l);
        for (k = 0; k < 10; k++) begin
            @(posedge pclk);
            #1;
            if (irq_take === 1'b1) break;
        end
        if (k == 10) fail_out();
        chk({irq_vector, irq_level}, {v, l});
    endtask
    task no_take;
        for (k = 0; k < 12; k++) begin
            @(posedge pclk);
            #1;
            if (irq_take === 1'b1) break;
        end
        chk(k, 12);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, return_from_interrupt_cmd, paddr, pwdata, irq_req} = '0;
        ext_reset_pin_n = 1'b1;
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(posedge pclk);
        #1;
        chk({core_reset, fetch_stall, sp_preset, port_latch, port_oe_n},
            26'h3_07ffff);
        @(posedge pclk);
        presetn <= 1'b1;
        wait_run();
        chk({boot_from_loader, ram_retained, boot_seen}, 3'b000);
        apb(1'b0, a_cfg, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, a_rf, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, a_lat, 32'h5a);
        apb(1'b1, a_mode, 32'h0f);
        #1;
        chk({port_latch, port_oe_n}, 16'h5af0);
        apb(1'b0, 12'hffc, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
        apb(1'b1, a_cc, 32'h80);
        repeat (12) @(posedge pclk);
        #1;
        chk({core_reset, fetch_stall}, 2'b00);
        $display("test power-on and lock done");
        unlock();
        apb(1'b1, a_cc, 32'h80);
        #1;
        chk(fetch_stall, 1'b1);
        n = 0;
        for (k = 0; k < 40; k++) begin
            if (core_reset === 1'b1) n++;
            @(posedge pclk);
            #1;
        end
        chk(n, 8);
        chk({ram_retained, boot_from_loader, port_latch, port_oe_n}, 18'h2_ffff);
        apb(1'b0, a_rf, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, a_cc, 32'h0);
        chk(rd[7], 1'b0);
        $display("test soft reset done");
        apb(1'b1, a_cfg, 32'h7f);
        @(posedge pclk);
        ext_reset_pin_n <= 1'b0;
        repeat (10) @(posedge pclk);
        ext_reset_pin_n <= 1'b1;
        wait_run();
        chk({boot_from_loader, boot_seen, ram_retained}, 3'b111);
        apb(1'b0, a_rf, 32'h0);
        chk(rd, 32'hc0);
        apb(1'b1, a_cfg, 32'hff);
        unlock();
        apb(1'b1, a_cc, 32'h82);
        repeat (2) @(posedge pclk);
        wait_run();
        chk({boot_from_loader, boot_seen}, 2'b11);
        $display("test boot select done");
        apb(1'b1, a_ph, 32'h8);
        apb(1'b1, a_pl, 32'h8);
        apb(1'b1, a_ie, 32'ha);
        irq_req <= 18'h2;
        no_take();
        apb(1'b1, a_ie, 32'h8000_000a);
        take_wait(16'h000b, 2'd0);
        irq_req <= 18'ha;
        take_wait(16'h001b, 2'd3);
        no_take();
        @(posedge pclk);
        return_from_interrupt_cmd <= 1'b1;
        @(posedge pclk);
        return_from_interrupt_cmd <= 1'b0;
        take_wait(16'h001b, 2'd3);
        irq_req <= 18'h0;
        unlock();
        apb(1'b1, a_cc, 32'h82);
        repeat (2) @(posedge pclk);
        wait_run();
        apb(1'b0, a_ie, 32'h0);
        chk(rd, 32'h0);
        $display("test interrupts done");
        give_verdict();
    end
endmodule
